//--- rtl/nvs_pkg.sv
// Package: timing constants and states of the save/restore sequencer
package nvs_pkg;
  localparam int CLK_MHZ = 50;
  localparam int CLK_NS = 20;
  // Times in their own units, as printed
  localparam int RESTORE_MS_HI = 20;
  localparam int RESTORE_MS_LO = 40;
  localparam int WRITE_GRACE_NS = 25;
  localparam int CMD_ACT_US = 500;
  localparam int STROBE_MIN_NS = 15;
  localparam int STROBE_REL_US = 5;
  localparam int DRIVE_HIGH_NS = 500;
  localparam int SLEEP_MS = 8;
  localparam int WAKE_MS_HI = 20;
  localparam int WAKE_MS_LO = 40;
  localparam int STANDBY_US = 100;
  localparam int SPIKE_NS_STD = 50;
  localparam int SPIKE_NS_HS = 10;
  localparam int SAVE_MS = 8;
  localparam int RECALL_US = 600;
  // Cycle counts: longest times round down, minimum one
  localparam int RESTORE_CYC_HI = RESTORE_MS_HI * 1000 * CLK_MHZ;
  localparam int RESTORE_CYC_LO = RESTORE_MS_LO * 1000 * CLK_MHZ;
  localparam int GRACE_CYC = (WRITE_GRACE_NS / CLK_NS) < 1 ? 1 :
    WRITE_GRACE_NS / CLK_NS;
  localparam int CMD_ACT_CYC = CMD_ACT_US * CLK_MHZ;
  localparam int REL_CYC = STROBE_REL_US * CLK_MHZ;
  localparam int DRIVE_CYC = DRIVE_HIGH_NS / CLK_NS;
  localparam int SLEEP_CYC = SLEEP_MS * 1000 * CLK_MHZ;
  localparam int WAKE_CYC_HI = WAKE_MS_HI * 1000 * CLK_MHZ;
  localparam int WAKE_CYC_LO = WAKE_MS_LO * 1000 * CLK_MHZ;
  localparam int STANDBY_CYC = STANDBY_US * CLK_MHZ;
  localparam int SPIKE_CYC_STD = (SPIKE_NS_STD + CLK_NS - 1) / CLK_NS;
  localparam int SPIKE_CYC_HS = (SPIKE_NS_HS + CLK_NS - 1) / CLK_NS;
  localparam int SAVE_CYC = SAVE_MS * 1000 * CLK_MHZ;
  localparam int RECALL_CYC = RECALL_US * CLK_MHZ;
  localparam int CW = 22;
  // Software command codes
  localparam logic [1:0] CMD_SAVE = 2'h0;
  localparam logic [1:0] CMD_RECALL = 2'h1;
  localparam logic [1:0] CMD_SLEEP = 2'h2;
  typedef enum logic [8:0] {
    ST_RESTORE = 9'h001,
    ST_IDLE = 9'h002,
    ST_GRACE = 9'h004,
    ST_SAVE = 9'h008,
    ST_RECALL = 9'h010,
    ST_HOLD = 9'h020,
    ST_DRIVE = 9'h040,
    ST_SLEEP = 9'h080,
    ST_WAKE = 9'h100
  } nvs_state_t;
endpackage

//--- rtl/nvs_sequencer.sv
// Save/restore sequencer of a nonvolatile static memory
module nvs_sequencer
  import nvs_pkg::*;
#(
  parameter int RESTORE_CYC_HI_P = nvs_pkg::RESTORE_CYC_HI,
  parameter int RESTORE_CYC_LO_P = nvs_pkg::RESTORE_CYC_LO,
  parameter int SAVE_CYC_P = nvs_pkg::SAVE_CYC,
  parameter int SLEEP_CYC_P = nvs_pkg::SLEEP_CYC,
  parameter int WAKE_CYC_HI_P = nvs_pkg::WAKE_CYC_HI,
  parameter int WAKE_CYC_LO_P = nvs_pkg::WAKE_CYC_LO,
  parameter int RECALL_CYC_P = nvs_pkg::RECALL_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic low_volt_var_i,
  input wire logic supply_ok_i,
  input wire logic hw_save_strobe_pin_i,
  output logic hw_save_strobe_pin_o,
  output logic hw_save_strobe_pin_oe_o,
  input wire logic array_write_i,
  input wire logic cmd_valid_i,
  input wire logic [1:0] cmd_i,
  input wire logic wake_i,
  input wire logic bus_stop_i,
  input wire logic bus_start_i,
  input wire logic hs_mode_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic scl_filt_o,
  output logic sda_filt_o,
  output logic access_inhibit_o,
  output logic array_write_en_o,
  output logic busy_o,
  output logic sleep_o,
  output logic standby_o,
  output logic save_pulse_o
);
  import nvs_pkg::*;

  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  nvs_state_t state, next_state;
  logic [CW-1:0] cnt, next_cnt;
  logic dirty, next_dirty;
  logic hw_req;
  logic [CW-1:0] restore_lim, wake_lim;
  logic access_inhibit, next_access_inhibit;
  logic write_en, next_write_en;
  logic drive, next_drive;
  logic save_pulse, next_save_pulse;
  logic sleep_q, next_sleep_q;
  logic [CW-1:0] sb_cnt, next_sb_cnt;
  logic standby, next_standby;
  logic [2:0] scl_cnt, next_scl_cnt, sda_cnt, next_sda_cnt;
  logic scl_f, next_scl_f, sda_f, next_sda_f;
  logic [2:0] spike_lim;

  // Save request from the strobe pin or from falling supply
  assign hw_req = !hw_save_strobe_pin_i || !supply_ok_i;
  assign restore_lim = low_volt_var_i ? CW'(RESTORE_CYC_LO_P - 1) :
    CW'(RESTORE_CYC_HI_P - 1);
  assign wake_lim = low_volt_var_i ? CW'(WAKE_CYC_LO_P - 1) :
    CW'(WAKE_CYC_HI_P - 1);
  assign spike_lim = hs_mode_i ? 3'(SPIKE_CYC_HS) : 3'(SPIKE_CYC_STD);

  always_comb begin
    next_state = state;
    next_cnt = cnt + 1'b1;
    next_dirty = dirty;
    next_drive = 1'b0;
    next_save_pulse = 1'b0;
    if (array_write_i && write_en) begin
      next_dirty = 1'b1;
    end
    case (state)
      ST_RESTORE: begin
        if (!supply_ok_i) begin
          next_cnt = '0;
        end else if (cnt >= restore_lim) begin
          next_state = ST_IDLE;
          next_dirty = 1'b0;
          next_drive = 1'b1;
          next_cnt = '0;
        end
      end
      ST_IDLE: begin
        next_cnt = '0;
        if (hw_req) begin
          next_state = ST_GRACE;
        end else if (cmd_valid_i) begin
          case (cmd_i)
            CMD_SAVE: next_state = ST_SAVE;
            CMD_RECALL: next_state = ST_RECALL;
            CMD_SLEEP: next_state = ST_SLEEP;
            default: next_state = ST_IDLE;
          endcase
        end
      end
      ST_GRACE: begin
        next_cnt = '0;
        if (cnt >= CW'(GRACE_CYC - 1)) begin
          // Clean array: no save, just hold until strobe is high with supply good
          next_state = (dirty || array_write_i) ? ST_SAVE : ST_HOLD;
          next_save_pulse = dirty || array_write_i;
        end else begin
          next_cnt = cnt + 1'b1;
        end
      end
      ST_SAVE: begin
        if (cnt >= CW'(SAVE_CYC_P - 1)) begin
          next_state = ST_HOLD;
          next_dirty = 1'b0;
          next_cnt = '0;
        end
      end
      ST_RECALL: begin
        if (cnt >= CW'(RECALL_CYC_P - 1)) begin
          next_state = ST_HOLD;
          next_dirty = 1'b0;
          next_cnt = '0;
        end
      end
      ST_HOLD: begin
        next_cnt = '0;
        if (!supply_ok_i) begin
          next_state = ST_HOLD;
        end else if (hw_save_strobe_pin_i) begin
          next_state = ST_DRIVE;
          next_drive = 1'b1;
        end
      end
      ST_DRIVE: begin
        next_state = ST_IDLE;
        next_cnt = '0;
      end
      ST_SLEEP: begin
        if (wake_i && sleep_q) begin
          next_state = ST_WAKE;
          next_cnt = '0;
        end else if (cnt >= CW'(SLEEP_CYC_P - 1)) begin
          next_cnt = cnt;
        end
      end
      ST_WAKE: begin
        if (cnt >= wake_lim) begin
          next_state = ST_IDLE;
          next_cnt = '0;
        end
      end
      default: begin
        next_state = ST_RESTORE;
        next_cnt = '0;
      end
    endcase
    // Supply loss during a restore restarts it
    if (!supply_ok_i && state inside {ST_RESTORE}) begin
      next_state = ST_RESTORE;
    end
    // Writes stay open only in idle with no save request; grace keeps them closed
    next_write_en = (next_state == ST_IDLE) && !hw_req;
    next_access_inhibit = (next_state != ST_IDLE) || !supply_ok_i ||
      hw_req;
    next_sleep_q = (state == ST_SLEEP) &&
      (sleep_q || cnt >= CW'(SLEEP_CYC_P - 1));
  end

  // Standby counter and input spike filters
  always_comb begin
    next_sb_cnt = sb_cnt;
    next_standby = standby;
    if (bus_start_i) begin
      next_sb_cnt = '0;
      next_standby = 1'b0;
    end else if (bus_stop_i) begin
      next_sb_cnt = CW'(STANDBY_CYC - 1);
    end else if (sb_cnt != '0) begin
      next_sb_cnt = sb_cnt - 1'b1;
      next_standby = (sb_cnt == CW'(1));
    end
    next_scl_cnt = '0;
    next_scl_f = scl_f;
    if (scl_i != scl_f) begin
      next_scl_cnt = scl_cnt + 1'b1;
      if (scl_cnt >= spike_lim) begin
        next_scl_f = scl_i;
        next_scl_cnt = '0;
      end
    end
    next_sda_cnt = '0;
    next_sda_f = sda_f;
    if (sda_i != sda_f) begin
      next_sda_cnt = sda_cnt + 1'b1;
      if (sda_cnt >= spike_lim) begin
        next_sda_f = sda_i;
        next_sda_cnt = '0;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= ST_RESTORE;
      cnt <= '0;
      dirty <= 1'b0;
      access_inhibit <= 1'b1;
      write_en <= 1'b0;
      drive <= 1'b0;
      save_pulse <= 1'b0;
      sleep_q <= 1'b0;
      sb_cnt <= '0;
      standby <= 1'b1;
      scl_cnt <= '0;
      sda_cnt <= '0;
      scl_f <= 1'b1;
      sda_f <= 1'b1;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      dirty <= next_dirty;
      access_inhibit <= next_access_inhibit;
      write_en <= next_write_en;
      drive <= next_drive;
      save_pulse <= next_save_pulse;
      sleep_q <= next_sleep_q;
      sb_cnt <= next_sb_cnt;
      standby <= next_standby;
      scl_cnt <= next_scl_cnt;
      sda_cnt <= next_sda_cnt;
      scl_f <= next_scl_f;
      sda_f <= next_sda_f;
    end
  end

  // One-cycle drive keeps well under the high-drive limit
  assign hw_save_strobe_pin_o = drive;
  assign hw_save_strobe_pin_oe_o = drive;
  assign access_inhibit_o = access_inhibit;
  assign array_write_en_o = write_en;
  assign busy_o = access_inhibit;
  assign sleep_o = sleep_q;
  assign standby_o = standby;
  assign save_pulse_o = save_pulse;
  assign scl_filt_o = scl_f;
  assign sda_filt_o = sda_f;

  a_grace_then_lock: assert property (
    state == ST_IDLE && hw_req |=> !write_en)
    else $error("write window not closed");
  a_clean_no_save: assert property (
    state == ST_GRACE && !dirty && !array_write_i && next_state != ST_GRACE
    |=> state == ST_HOLD)
    else $error("save on clean array");
  a_inhibit_busy: assert property (
    state inside {ST_SAVE, ST_RECALL, ST_RESTORE} |-> access_inhibit)
    else $error("access open during operation");
  a_cmd_acts: assert property (
    state == ST_IDLE && cmd_valid_i && !hw_req && cmd_i == CMD_RECALL
    |=> state == ST_RECALL)
    else $error("command not acted on");
  a_sw_lock: assert property (
    $rose(state == ST_SAVE) |=> access_inhibit [*8])
    else $error("bus not locked in save");
  a_strobe_release: assert property (
    state == ST_HOLD && hw_save_strobe_pin_i && supply_ok_i
    |=> ##1 !access_inhibit)
    else $error("not released after strobe high");
  a_drive_short: assert property (
    drive |=> !drive)
    else $error("strobe driven too long");
  a_hold_low: assert property (
    !hw_save_strobe_pin_i |=> access_inhibit && !write_en)
    else $error("array open with strobe low");
  a_standby_load: assert property (
    bus_stop_i && !bus_start_i |=> sb_cnt == CW'(STANDBY_CYC - 1))
    else $error("standby count not loaded");
  a_standby_time: assert property (
    sb_cnt == CW'(1) && !bus_start_i && !bus_stop_i |=> standby)
    else $error("standby not reached in time");
  c_hw_save: cover property (state == ST_GRACE ##1 state == ST_SAVE);
  c_sw_recall: cover property (state == ST_RECALL ##1 state == ST_HOLD);
  c_sleep_wake: cover property (state == ST_SLEEP ##1 state == ST_WAKE);
  c_clean_skip: cover property (state == ST_GRACE ##1 state == ST_HOLD);
endmodule

//--- tb/nvs_strobe_drv.sv
// Model of the outside party pulling the save strobe pin low
module nvs_strobe_drv (
  input wire logic clk_i,
  output logic pull_low_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial pull_low_o = 1'b0;
  // Whole cycles only, so never shorter than 15 ns
  task automatic pulse(input int n);
    @(negedge clk_i);
    pull_low_o = 1'b1;
    repeat (n) @(negedge clk_i);
    pull_low_o = 1'b0;
  endtask
endmodule

//--- tb/nvs_sequencer_tb.sv
// Self-checking bench of the save/restore sequencer
module nvs_sequencer_tb;
  import nvs_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int RH = 30;
  localparam int RL = 40;
  localparam int SV = 20;
  localparam int SL = 20;
  localparam int RC = 20;
  logic clk_i = 0, rst_i = 1, lv = 0, sup = 1, wr = 0, cv = 0, wake = 0;
  logic stop = 0, start = 0, hs = 0, scl = 1, sda = 1;
  logic [1:0] cmd = 2'h0;
  logic pin_o, pin_oe, pull, pin, sclf, sdaf, inh, wen, busy, slp, sb, sp;
  logic pv_sl = 0, pv_sb = 1;
  logic [1:0] exp_q[$];
  int n_fail = 0, n_checks = 0, oe_n = 0;
  // Pull-up wins unless someone drives
  assign pin = pin_oe ? pin_o : !pull;
  nvs_sequencer #(.RESTORE_CYC_HI_P(RH), .RESTORE_CYC_LO_P(RL),
    .SAVE_CYC_P(SV), .SLEEP_CYC_P(SL), .WAKE_CYC_HI_P(RH),
    .WAKE_CYC_LO_P(RL), .RECALL_CYC_P(RC)) uut (.clk_i(clk_i),
    .rst_i(rst_i), .low_volt_var_i(lv), .supply_ok_i(sup),
    .hw_save_strobe_pin_i(pin), .hw_save_strobe_pin_o(pin_o),
    .hw_save_strobe_pin_oe_o(pin_oe), .array_write_i(wr),
    .cmd_valid_i(cv), .cmd_i(cmd), .wake_i(wake), .bus_stop_i(stop),
    .bus_start_i(start), .hs_mode_i(hs), .scl_i(scl), .sda_i(sda),
    .scl_filt_o(sclf), .sda_filt_o(sdaf), .access_inhibit_o(inh),
    .array_write_en_o(wen), .busy_o(busy), .sleep_o(slp),
    .standby_o(sb), .save_pulse_o(sp));
  nvs_strobe_drv drv (.clk_i(clk_i), .pull_low_o(pull));
  initial begin
    forever #10 clk_i = ~clk_i;
  end
  task automatic chk(input logic got, input logic e);
    n_checks++;
    if (got !== e) begin
      n_fail++;
      $display("[FAIL] %0t flag %b expected %b", $time, got, e);
    end
  endtask
  task automatic chk_ev(input logic [1:0] got);
    n_checks++;
    if (exp_q.size() == 0 || exp_q[0] !== got) begin
      n_fail++;
      $display("[FAIL] %0t unexpected event %0d", $time, got);
    end
    if (exp_q.size() != 0) void'(exp_q.pop_front());
  endtask
  function automatic logic sig(input int k);
    return k == 0 ? inh : (k == 1 ? slp : sb);
  endfunction
  task automatic wait_sig(input int k, input logic v, input int lim);
    for (int i = 0; i < lim && sig(k) !== v; i++) @(negedge clk_i);
    chk(sig(k), v);
  endtask
  task automatic write1();
    wr = 1'b1;
    @(negedge clk_i);
    wr = 1'b0;
  endtask
  task automatic give_verdict();
    if (exp_q.size() != 0) n_fail++;
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Event watcher: each seen result consumes the oldest note
  always @(negedge clk_i) begin
    if (sp === 1'b1) chk_ev(2'h0);
    if (pin_oe === 1'b1) chk(pin_o, 1'b1);
    if (slp === 1'b1 && pv_sl !== 1'b1) chk_ev(2'h1);
    if (sb === 1'b1 && pv_sb !== 1'b1 && !rst_i) chk_ev(2'h2);
    pv_sl = slp;
    pv_sb = sb;
    oe_n = pin_oe === 1'b1 ? oe_n + 1 : 0;
    if (oe_n == DRIVE_CYC + 1) chk(1'b0, 1'b1);
  end
  initial begin
    #(30000 * 20);
    n_fail++;
    give_verdict();
  end
  initial begin
    void'($urandom(32'hb9fd2191));
    repeat (2) @(negedge clk_i);
    rst_i = 0;
    wait_sig(0, 1'b0, RH + 5);
    chk(wen, 1'b1);
    // Pin saves then supply saves, dirty and clean
    for (int k = 0; k < 4; k++) begin
      if (k % 2 == 0) begin
        write1();
        exp_q.push_back(2'h0);
      end
      if (k < 2) begin
        fork drv.pulse(2 + $urandom_range(0, 4)); join_none
        repeat (3) @(negedge clk_i);
        chk(inh, 1'b1);
        chk(wen, 1'b0);
        wait_sig(0, 1'b0, SV + 12);
      end else begin
        sup = 0;
        repeat (3) @(negedge clk_i);
        chk(inh, 1'b1);
        repeat (SV + 5) @(negedge clk_i);
        rst_i = 1;
        lv = 1'($urandom());
        @(negedge clk_i);
        sup = 1;
        rst_i = 0;
        wait_sig(0, 1'b0, (lv ? RL : RH) + 5);
      end
    end
    // Every command code, spare code last
    for (int c = 0; c < 4; c++) begin
      write1();
      cmd = 2'(c);
      cv = 1;
      @(negedge clk_i);
      cv = 0;
      if (c == 3) begin
        repeat (3) @(negedge clk_i);
        chk(inh, 1'b0);
      end else if (c == 2) begin
        exp_q.push_back(2'h1);
        wait_sig(1, 1'b1, SL + 5);
        wake = 1;
        @(negedge clk_i);
        wake = 0;
        wait_sig(1, 1'b0, 5);
        wait_sig(0, 1'b0, (lv ? RL : RH) + 5);
      end else begin
        @(negedge clk_i);
        chk(inh, 1'b1);
        chk(busy, 1'b1);
        wait_sig(0, 1'b0, (c == 1 ? RC : SV) + 5);
      end
    end
    start = 1;
    @(negedge clk_i);
    start = 0;
    stop = 1;
    exp_q.push_back(2'h2);
    @(negedge clk_i);
    stop = 0;
    wait_sig(2, 1'b1, STANDBY_CYC + 5);
    // One-cycle spike must not pass, long low must
    scl = 0;
    @(negedge clk_i);
    scl = 1;
    repeat (4) begin
      @(negedge clk_i);
      chk(sclf, 1'b1);
    end
    sda = 0;
    repeat (6) @(negedge clk_i);
    chk(sdaf, 1'b0);
    // High-speed mode: one-cycle spike blocked, three-cycle low passes
    hs = 1;
    scl = 0;
    @(negedge clk_i);
    scl = 1;
    repeat (2) @(negedge clk_i);
    chk(sclf, 1'b1);
    scl = 0;
    repeat (3) @(negedge clk_i);
    chk(sclf, 1'b0);
    give_verdict();
  end
endmodule
